// [design/gicb_bank.sv]
// global interrupt register and device configuration register bank
// assumes all event, level and strobe inputs except gpio_pin come from
// logic on mclk; register port is a simple byte-lane local port
`timescale 1ns/1ps

module gicb_bank #(
    parameter logic [7:0] DEVICE_CODE   = 8'h5A,  // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h01   // arbitrary value
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [3:0]  reg_be,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    input  wire logic [7:0]  rx_data_ready,
    input  wire logic [7:0]  rx_timeout,
    input  wire logic [7:0]  line_error_evt,
    input  wire logic [7:0]  line_stat_read,
    input  wire logic [7:0]  tx_ready_evt,
    input  wire logic [7:0]  flow_detect_evt,
    input  wire logic [7:0]  int_stat_read,
    input  wire logic [7:0]  modem_evt,
    input  wire logic [7:0]  modem_stat_read,
    input  wire logic        timer_timeout,
    output logic      [3:0]  timer_cmd,
    output logic             timer_cmd_valid,
    output logic      [15:0] timer_period,
    input  wire logic        wake_evt,
    input  wire logic [7:0]  gpio_pin,
    output logic      [7:0]  gpio_out,
    output logic      [7:0]  gpio_tristate,
    output logic      [7:0]  gpio_select,
    output logic      [7:0]  sample_rate_select,
    output logic      [7:0]  sleep_control,
    output logic      [7:0]  soft_reset_req,
    input  wire logic [7:0]  soft_reset_done,
    output logic      [7:0]  spare_b,
    output logic             irq_req
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [2:0] gicb_code(input logic rx, input logic to,
                                             input logic tx, input logic ms,
                                             input logic mp, input logic tm);
        if (rx)      gicb_code = gicb_pkg::SRC_RX;
        else if (to) gicb_code = gicb_pkg::SRC_RX_TIMEOUT;
        else if (tx) gicb_code = gicb_pkg::SRC_TX_READY;
        else if (ms) gicb_code = gicb_pkg::SRC_MODEM;
        else if (mp) gicb_code = gicb_pkg::SRC_GPIO;
        else if (tm) gicb_code = gicb_pkg::SRC_TIMER;
        else         gicb_code = gicb_pkg::SRC_NONE;
    endfunction

    // true when lane carrying byte offset ofs is accessed
    function automatic logic gicb_hit(input logic [7:0] addr, input logic [3:0] be,
                                      input logic [7:0] ofs);
        gicb_hit = (addr[7:2] == ofs[7:2]) && be[ofs[1:0]];
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    logic [7:0]  line_pend;
    logic [7:0]  tx_pend;
    logic [7:0]  flow_pend;
    logic [7:0]  modem_pend;
    logic        timer_pend;
    logic        timer_irq_en;
    logic        gpio_pend;
    logic        wake_pend;
    logic [7:0]  gpio_sync_a;
    logic [7:0]  gpio_sync_b;
    logic        gpio_hit_q;
    logic [7:0]  gpio_level;
    logic [7:0]  gpio_invert;
    logic [7:0]  gpio_irq_mask;
    logic [7:0]  flags;
    logic [23:0] codes;
    logic [7:0]  gpio_seen;
    logic        gpio_hit;
    logic        rd_flags;
    logic        rd_tcmd;
    logic        rd_glvl;
    logic [31:0] next_rdata;

    assign rd_flags = reg_rd && gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_IRQ_FLAGS);
    assign rd_tcmd  = reg_rd && gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_TIMER_COMMAND);
    assign rd_glvl  = reg_rd && gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_GPIO_LEVEL);

    // ****************************************
    // per-channel sticky sources
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            line_pend  <= gicb_pkg::RST_ZERO;
            tx_pend    <= gicb_pkg::RST_ZERO;
            flow_pend  <= gicb_pkg::RST_ZERO;
            modem_pend <= gicb_pkg::RST_ZERO;
        end else begin
            line_pend  <= line_error_evt | (line_pend & ~line_stat_read);
            tx_pend    <= tx_ready_evt | (tx_pend & ~int_stat_read);
            flow_pend  <= flow_detect_evt | (flow_pend & ~int_stat_read);
            modem_pend <= modem_evt | (modem_pend & ~modem_stat_read);
        end
    end

    // ****************************************
    // flags and source codes
    // ****************************************
    always_comb begin
        for (int i = 0; i < gicb_pkg::NUM_CH; i++) begin
            // receive sources follow the fifo level directly
            flags[i] = rx_data_ready[i] | rx_timeout[i] | line_pend[i]
                     | tx_pend[i] | flow_pend[i] | modem_pend[i];
            codes[i*gicb_pkg::CODE_W +: gicb_pkg::CODE_W] =
                gicb_code(rx_data_ready[i] | line_pend[i], rx_timeout[i], tx_pend[i],
                          modem_pend[i] | flow_pend[i],
                          (i == 0) && gpio_pend, (i == 0) && timer_pend);
        end
        flags[0] = flags[0] | gpio_pend | timer_pend;
    end

    // ****************************************
    // wake-up indicator
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_pend <= 1'b0;
        end else begin
            wake_pend <= (wake_evt && sleep_control == gicb_pkg::ALL_ASLEEP)
                       | (wake_pend & ~rd_flags);
        end
    end

    // ****************************************
    // timer command and interrupt
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_irq_en    <= 1'b0;
            timer_pend      <= 1'b0;
            timer_cmd       <= 4'h0;
            timer_cmd_valid <= 1'b0;
        end else begin
            timer_cmd_valid <= 1'b0;
            timer_pend      <= (timer_timeout & timer_irq_en)
                             | (timer_pend & ~rd_tcmd);
            if (reg_wr && gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_TIMER_COMMAND)) begin
                timer_cmd       <= reg_wdata[3:0];
                timer_cmd_valid <= 1'b1;
                case (reg_wdata[3:0])
                    gicb_pkg::TCMD_IRQ_ENABLE: begin
                        timer_irq_en <= 1'b1;
                    end
                    gicb_pkg::TCMD_IRQ_DISABLE: begin
                        timer_irq_en <= 1'b0;
                    end
                    gicb_pkg::TCMD_RESET: begin
                        timer_irq_en <= 1'b0;
                        timer_pend   <= 1'b0;
                    end
                    default: begin
                        timer_irq_en <= timer_irq_en;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // pin interrupt
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            gpio_sync_a <= gicb_pkg::RST_ZERO;
            gpio_sync_b <= gicb_pkg::RST_ZERO;
            gpio_hit_q  <= 1'b0;
            gpio_pend   <= 1'b0;
        end else begin
            gpio_sync_a <= gpio_pin;
            gpio_sync_b <= gpio_sync_a;
            gpio_hit_q  <= gpio_hit;
            gpio_pend   <= (gpio_hit & ~gpio_hit_q) | (gpio_pend & ~rd_glvl);
        end
    end

    assign gpio_seen = gpio_sync_b ^ gpio_invert;
    assign gpio_hit  = |(gpio_seen & gpio_select & gpio_irq_mask);

    // ****************************************
    // writable registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_period       <= {gicb_pkg::RST_ZERO, gicb_pkg::RST_ZERO};
            sample_rate_select <= gicb_pkg::RST_ZERO;
            sleep_control      <= gicb_pkg::RST_ZERO;
            spare_b            <= gicb_pkg::RST_ZERO;
            gpio_irq_mask      <= gicb_pkg::RST_ZERO;
            gpio_level         <= gicb_pkg::RST_ZERO;
            gpio_tristate      <= gicb_pkg::RST_ZERO;
            gpio_invert        <= gicb_pkg::RST_ZERO;
            gpio_select        <= gicb_pkg::RST_GPIO_SELECT;
        end else if (reg_wr) begin
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_PERIOD_LOW))
                timer_period[7:0] <= reg_wdata[23:16];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_PERIOD_HIGH))
                timer_period[15:8] <= reg_wdata[31:24];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_SAMPLE_RATE))
                sample_rate_select <= reg_wdata[7:0];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_SLEEP))
                sleep_control <= reg_wdata[31:24];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_SPARE_B))
                spare_b <= reg_wdata[23:16];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_GPIO_IRQ_MASK))
                gpio_irq_mask <= reg_wdata[31:24];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_GPIO_LEVEL))
                gpio_level <= reg_wdata[7:0];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_GPIO_TRISTATE))
                gpio_tristate <= reg_wdata[15:8];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_GPIO_INVERT))
                gpio_invert <= reg_wdata[23:16];
            if (gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_GPIO_SELECT))
                gpio_select <= reg_wdata[31:24];
        end
    end

    assign gpio_out = gpio_level;

    // ****************************************
    // soft reset requests
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            soft_reset_req <= gicb_pkg::RST_ZERO;
        end else if (reg_wr && gicb_hit(reg_addr, reg_be, gicb_pkg::OFS_SOFT_RESET)) begin
            soft_reset_req <= reg_wdata[23:16] | (soft_reset_req & ~soft_reset_done);
        end else begin
            soft_reset_req <= soft_reset_req & ~soft_reset_done;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (reg_addr[7:2])
            gicb_pkg::OFS_IRQ_FLAGS[7:2]: begin
                next_rdata = {codes, flags};
            end
            gicb_pkg::OFS_TIMER_COMMAND[7:2]: begin
                next_rdata[7:0]   = (timer_pend && timer_irq_en) ?
                                    gicb_pkg::TIMER_PENDING_READ : gicb_pkg::RST_ZERO;
                next_rdata[31:16] = timer_period;
            end
            gicb_pkg::OFS_SAMPLE_RATE[7:2]: begin
                next_rdata[7:0]   = sample_rate_select;
                next_rdata[31:24] = sleep_control;
            end
            gicb_pkg::OFS_REVISION[7:2]: begin
                next_rdata[7:0]   = REVISION_CODE;
                next_rdata[15:8]  = DEVICE_CODE;
                next_rdata[31:24] = gpio_irq_mask;
            end
            gicb_pkg::OFS_GPIO_LEVEL[7:2]: begin
                next_rdata = {gpio_select, gpio_invert, gpio_tristate,
                              (gpio_select & gpio_seen) | (~gpio_select & gpio_level)};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
        for (int b = 0; b < 4; b++) begin
            if (!reg_be[b])
                next_rdata[b*8 +: 8] = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= next_rdata;
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= (|flags) | wake_pend;
        end
    end

endmodule // gicb_bank

// [pkg/gicb_pkg.sv]
// constants for the global interrupt and configuration register bank
// assumes byte offsets 0x080..0x093 decoded from an 8-bit local address
package gicb_pkg;

    localparam int unsigned NUM_CH = 8;

    // ****************************************
    // byte offsets
    // ****************************************
    localparam logic [7:0] OFS_IRQ_FLAGS      = 8'h80;
    localparam logic [7:0] OFS_CODE_LOW       = 8'h81;
    localparam logic [7:0] OFS_CODE_MID       = 8'h82;
    localparam logic [7:0] OFS_CODE_HIGH      = 8'h83;
    localparam logic [7:0] OFS_TIMER_COMMAND  = 8'h84;
    localparam logic [7:0] OFS_TIMER_SPARE    = 8'h85;
    localparam logic [7:0] OFS_PERIOD_LOW     = 8'h86;
    localparam logic [7:0] OFS_PERIOD_HIGH    = 8'h87;
    localparam logic [7:0] OFS_SAMPLE_RATE    = 8'h88;
    localparam logic [7:0] OFS_SPARE_A        = 8'h89;
    localparam logic [7:0] OFS_SOFT_RESET     = 8'h8A;
    localparam logic [7:0] OFS_SLEEP          = 8'h8B;
    localparam logic [7:0] OFS_REVISION       = 8'h8C;
    localparam logic [7:0] OFS_DEVICE_CODE    = 8'h8D;
    localparam logic [7:0] OFS_SPARE_B        = 8'h8E;
    localparam logic [7:0] OFS_GPIO_IRQ_MASK  = 8'h8F;
    localparam logic [7:0] OFS_GPIO_LEVEL     = 8'h90;
    localparam logic [7:0] OFS_GPIO_TRISTATE  = 8'h91;
    localparam logic [7:0] OFS_GPIO_INVERT    = 8'h92;
    localparam logic [7:0] OFS_GPIO_SELECT    = 8'h93;

    // ****************************************
    // reset values and all-asleep pattern
    // ****************************************
    localparam logic [7:0] RST_ZERO           = 8'h00;
    localparam logic [7:0] RST_GPIO_SELECT    = 8'hFF;
    localparam logic [7:0] ALL_ASLEEP         = 8'hFF;

    // ****************************************
    // source codes
    // ****************************************
    localparam logic [2:0] SRC_NONE           = 3'h0;
    localparam logic [2:0] SRC_RX             = 3'h1;
    localparam logic [2:0] SRC_RX_TIMEOUT     = 3'h2;
    localparam logic [2:0] SRC_TX_READY       = 3'h3;
    localparam logic [2:0] SRC_MODEM          = 3'h4;
    localparam logic [2:0] SRC_GPIO           = 3'h6;
    localparam logic [2:0] SRC_TIMER          = 3'h7;
    localparam int unsigned CODE_W            = 3;
    localparam int unsigned CODE_BASE         = 8;

    // ****************************************
    // timer commands
    // ****************************************
    localparam logic [3:0] TCMD_IRQ_ENABLE    = 4'h1;
    localparam logic [3:0] TCMD_IRQ_DISABLE   = 4'h2;
    localparam logic [3:0] TCMD_RESET         = 4'hB;
    localparam logic [7:0] TIMER_PENDING_READ = 8'h01;

endpackage

// [sim/gicb_bank_asserts.sv]
// port assertions for the interrupt and configuration bank
// assumes it is bound to gicb_bank, one clock, sync reset
`timescale 1ns/1ps
module gicb_bank_asserts (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [3:0]  reg_be,
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic [7:0]  line_error_evt,
    input wire logic [3:0]  timer_cmd,
    input wire logic        timer_cmd_valid,
    input wire logic [15:0] timer_period,
    input wire logic [7:0]  gpio_select,
    input wire logic [7:0]  soft_reset_req,
    input wire logic [7:0]  soft_reset_done,
    input wire logic        irq_req
);
    // ****************************************
    // helpers
    // ****************************************
    logic [31:0] wd_q;
    always_ff @(posedge mclk) begin
        wd_q <= reg_wdata;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ****************************************
    // properties
    // ****************************************
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no answer");
    a_rdata_stands: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
        else $error("read data moved without a read");
    a_irq_follows: assert property (|line_error_evt |-> ##[1:2] irq_req)
        else $error("request missing after channel event");
    a_reset_values: assert property ($fell(rst) |->
        gpio_select == 8'hFF && !irq_req && soft_reset_req == 8'h00)
        else $error("wrong value after reset");
    a_tcmd_forward: assert property (reg_wr && reg_addr[7:2] == 6'h21 && reg_be[0]
        |=> timer_cmd_valid && timer_cmd == wd_q[3:0])
        else $error("timer command not forwarded");
    a_period_write: assert property (reg_wr && reg_addr[7:2] == 6'h21 && reg_be[3]
        |=> timer_period[15:8] == wd_q[31:24])
        else $error("period high byte not written");
    a_select_write: assert property (reg_wr && reg_addr[7:2] == 6'h24 && reg_be[3]
        |=> gpio_select == wd_q[31:24])
        else $error("pin select not written");
    a_srst_hold: assert property (1'b1 |=>
        (($past(soft_reset_req) & ~$past(soft_reset_done)) & ~soft_reset_req) == 8'h00)
        else $error("soft reset bit dropped early");
    a_srst_clear: assert property (soft_reset_done != 8'h00 && !reg_wr
        |=> (soft_reset_req & $past(soft_reset_done)) == 8'h00)
        else $error("soft reset bit did not self clear");
endmodule // gicb_bank_asserts

bind gicb_bank gicb_bank_asserts u_chk (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .line_error_evt(line_error_evt), .timer_cmd(timer_cmd),
    .timer_cmd_valid(timer_cmd_valid), .timer_period(timer_period),
    .gpio_select(gpio_select), .soft_reset_req(soft_reset_req),
    .soft_reset_done(soft_reset_done), .irq_req(irq_req)
);

// [sim/gicb_host.sv]
// host side model issuing byte-lane register reads and writes
// assumes the bank answers a read exactly one cycle later
`timescale 1ns/1ps
module gicb_host (
    input  wire logic        mclk,
    output logic      [7:0]  reg_addr,
    output logic      [3:0]  reg_be,
    output logic             reg_rd,
    output logic             reg_wr,
    output logic      [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_be = 4'h0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 32'h0;
    end
    // ****************************************
    // bus cycles
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_be <= be;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] be, output logic [31:0] q,
                      output logic ok);
        @(posedge mclk);
        reg_addr <= a;
        reg_be <= be;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        ok = reg_rvalid;
        q = reg_rdata;
    endtask
endmodule // gicb_host

// [sim/global_irq_config_bank_test.sv]
// self-checking bench for the interrupt and configuration bank
// assumes gicb_bank, gicb_host and the bound checker are compiled first
`timescale 1ns/1ps
module global_irq_config_bank_test;
    localparam logic [7:0] DEV = 8'hC3; // arbitrary value
    localparam logic [7:0] REV = 8'h02; // arbitrary value
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr, rx_data_ready, rx_timeout, line_error_evt, line_stat_read, tx_ready_evt;
    logic [7:0]  flow_detect_evt, int_stat_read, modem_evt, modem_stat_read, gpio_pin;
    logic [7:0]  gpio_out, gpio_tristate, gpio_select, sample_rate_select, sleep_control;
    logic [7:0]  soft_reset_req, spare_b, soft_reset_done;
    logic [3:0]  reg_be, timer_cmd;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] timer_period;
    logic        reg_rd, reg_wr, reg_rvalid, timer_timeout, timer_cmd_valid, wake_evt, irq_req;
    int          error_cnt = 0;
    int          checks = 0;
    int          ch, k;
    always #5 mclk = ~mclk;
    gicb_bank #(.DEVICE_CODE(DEV), .REVISION_CODE(REV)) uut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_be(reg_be), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .rx_data_ready(rx_data_ready), .rx_timeout(rx_timeout),
        .line_error_evt(line_error_evt), .line_stat_read(line_stat_read),
        .tx_ready_evt(tx_ready_evt), .flow_detect_evt(flow_detect_evt),
        .int_stat_read(int_stat_read), .modem_evt(modem_evt),
        .modem_stat_read(modem_stat_read), .timer_timeout(timer_timeout), .timer_cmd(timer_cmd),
        .timer_cmd_valid(timer_cmd_valid), .timer_period(timer_period),
        .wake_evt(wake_evt), .gpio_pin(gpio_pin), .gpio_out(gpio_out),
        .gpio_tristate(gpio_tristate), .gpio_select(gpio_select),
        .sample_rate_select(sample_rate_select), .sleep_control(sleep_control),
        .soft_reset_req(soft_reset_req), .soft_reset_done(soft_reset_done),
        .spare_b(spare_b), .irq_req(irq_req)
    );
    gicb_host u_host (
        .mclk(mclk), .reg_addr(reg_addr), .reg_be(reg_be), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [2:0] exp_code(input int kind);
        return kind == 0 ? 3'h1 : kind == 1 ? 3'h3 : 3'h4;
    endfunction
    function automatic logic [31:0] exp_int(input int c, input logic [2:0] code);
        return (32'h1 << c) | ({29'h0, code} << (8 + 3 * c));
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] e);
        logic [31:0] q;
        logic        ok;
        u_host.rd(a, be, q, ok);
        chk("rvalid", 32'h1, {31'h0, ok});
        chk(n, e, q);
    endtask
    task automatic pulse(input int kind, input logic [7:0] m);
        @(posedge mclk);
        case (kind)
            0: line_error_evt <= m;
            1: tx_ready_evt <= m;
            2: flow_detect_evt <= m;
            3: modem_evt <= m;
            4: line_stat_read <= m;
            5: int_stat_read <= m;
            6: modem_stat_read <= m;
            7: soft_reset_done <= m;
            8: wake_evt <= m[0];
            default: timer_timeout <= m[0];
        endcase
        @(posedge mclk);
        {line_error_evt, tx_ready_evt, flow_detect_evt, modem_evt} <= 32'h0;
        {line_stat_read, int_stat_read, modem_stat_read, soft_reset_done} <= 32'h0;
        {wake_evt, timer_timeout} <= 2'h0;
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        {rx_data_ready, rx_timeout, line_error_evt, line_stat_read, tx_ready_evt} = 40'h0;
        {flow_detect_evt, int_stat_read, modem_evt, modem_stat_read, gpio_pin} = 40'h0;
        {soft_reset_done, timer_timeout, wake_evt} = 10'h0;
        void'($urandom(75));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rc("irq", 8'h80, 4'hF, 32'h0);
        rc("timer", 8'h84, 4'hF, 32'h0);
        rc("anc1", 8'h88, 4'hF, 32'h0);
        rc("anc2", 8'h8C, 4'hF, {16'h0, DEV, REV});
        rc("gpio", 8'h90, 4'hF, 32'hFF00_0000);
        rc("unmapped", 8'h94, 4'hF, 32'h0);
        u_host.wr(8'h80, 4'hF, 32'hFFFF_FFFF);
        u_host.wr(8'h8C, 4'hF, 32'hFFFF_FFFF);
        rc("ro irq", 8'h80, 4'hF, 32'h0);
        rc("ro id", 8'h8C, 4'h3, {16'h0, DEV, REV});
        chk("spare_b", 32'hFF, {24'h0, spare_b});
        for (int i = 0; i < 24; i++) begin
            ch = $urandom % 8;
            k = $urandom % 4;
            pulse(k, 8'h1 << ch);
            rc("set", 8'h80, 4'hF, exp_int(ch, exp_code(k)));
            rc("flags", 8'h80, 4'h1, 32'h1 << ch);
            pulse(k == 0 ? 4 : k == 3 ? 6 : 5, 8'h1 << ch);
            rc("clear", 8'h80, 4'hF, 32'h0);
        end
        pulse(3, 8'h80);
        pulse(1, 8'h80);
        pulse(0, 8'h80);
        for (int j = 0; j < 3; j++) begin
            rc("prio", 8'h80, 4'hF, exp_int(7, exp_code(j == 2 ? 3 : j)));
            pulse(4 + j, 8'h80);
        end
        rc("prio", 8'h80, 4'hF, 32'h0);
        @(posedge mclk);
        rx_data_ready <= 8'h04;
        rx_timeout <= 8'h04;
        rc("rx", 8'h80, 4'hF, exp_int(2, 3'h1));
        @(posedge mclk);
        rx_data_ready <= 8'h00;
        rc("rx tmo", 8'h80, 4'hF, exp_int(2, 3'h2));
        @(posedge mclk);
        rx_timeout <= 8'h00;
        rc("rx gone", 8'h80, 4'hF, 32'h0);
        u_host.wr(8'h84, 4'hF, 32'h1234_0001);
        chk("period", 32'h1234, {16'h0, timer_period});
        pulse(9, 8'h01);
        rc("tmr code", 8'h80, 4'h2, 32'h0700);
        rc("tmr cmd", 8'h84, 4'h1, 32'h1);
        rc("tmr cmd", 8'h84, 4'h1, 32'h0);
        rc("tmr code", 8'h80, 4'h2, 32'h0);
        u_host.wr(8'h84, 4'h1, 32'h2);
        pulse(9, 8'h01);
        rc("tmr off", 8'h80, 4'h2, 32'h0);
        @(posedge mclk);
        gpio_pin <= 8'h01;
        repeat (5) @(posedge mclk);
        rc("pin code", 8'h80, 4'hE, 32'h0600);
        rc("pin level", 8'h90, 4'h1, 32'h1);
        rc("pin code", 8'h80, 4'hE, 32'h0);
        pulse(8, 8'h01);
        repeat (2) @(posedge mclk);
        #1 chk("wake awake", 32'h0, {31'h0, irq_req});
        u_host.wr(8'h88, 4'h8, 32'hFF00_0000);
        pulse(8, 8'h01);
        repeat (2) @(posedge mclk);
        #1 chk("wake irq", 32'h1, {31'h0, irq_req});
        rc("wake code", 8'h80, 4'hF, 32'h0);
        repeat (2) @(posedge mclk);
        #1 chk("wake clr", 32'h0, {31'h0, irq_req});
        u_host.wr(8'h88, 4'h4, 32'h0005_0000);
        chk("srst", 32'h05, {24'h0, soft_reset_req});
        rc("srst rd", 8'h88, 4'h4, 32'h0);
        pulse(7, 8'h05);
        chk("srst done", 32'h0, {24'h0, soft_reset_req});
        u_host.wr(8'h90, 4'h8, 32'h0F00_0000);
        chk("select", 32'h0F, {24'h0, gpio_select});
        chk("sleep", 32'hFF, {24'h0, sleep_control});
        u_host.wr(8'h88, 4'h1, 32'h0000_005A);
        chk("rate", 32'h5A, {24'h0, sample_rate_select});
        u_host.wr(8'h90, 4'h3, 32'h0000_C33C);
        chk("level", 32'h3C, {24'h0, gpio_out});
        chk("tristate", 32'hC3, {24'h0, gpio_tristate});
        rc("anc2 hi", 8'h8C, 4'hC, 32'hFF00_0000);
        u_host.wr(8'h84, 4'h1, 32'h0000_0001);
        pulse(9, 8'h01);
        u_host.wr(8'h84, 4'h1, 32'h0000_000B);
        rc("tmr rst code", 8'h80, 4'h2, 32'h0);
        rc("tmr rst cmd", 8'h84, 4'h1, 32'h0);
        finish_test();
    end
endmodule // global_irq_config_bank_test
